// File: rtl/drive_serial_register_map.sv
/*
 * Register bank of the drive, reached by unframed request bytes
 * (function code onward, address and check bytes removed by the link
 * framer) and answering with unframed response bytes.
 * Assumes the framer marks the first and last byte of every request.
 */
`timescale 1ns/100ps
`include "drive_regs_consts.svh"
module drive_serial_register_map #(
   parameter int MAX_QTY = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic req_valid,
   input wire drive_regs_pkg::req_byte_type req,
   output logic req_ready,
   output logic rsp_valid,
   output drive_regs_pkg::rsp_byte_type rsp,
   input wire logic rsp_ready,
   input wire drive_regs_pkg::drive_state_type drive_state,
   input wire logic [15:0] fault_in,
   output logic run_cmd,
   output logic reverse_cmd,
   output logic remote_external_fault,
   output logic fault_reset_pulse,
   output logic [4:0] remote_input_cmd,
   output logic [15:0] speed_setpoint,
   output logic [15:0] pid_setpoint,
   output logic pid_setpoint_valid,
   output logic [15:0] analog_out_one,
   output logic [15:0] analog_out_two,
   output logic relay_output_contact,
   output logic photocoupler_out_one,
   output logic photocoupler_out_two,
   output logic fault_relay_contact,
   output logic [2:0] broadcast_enable
);
   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   if (MAX_QTY < 1 || MAX_QTY > 16) begin : g_bad_qty
      $error("MAX_QTY must lie between 1 and 16");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   drive_regs_pkg::parse_state_type st_q;
   drive_regs_pkg::rsp_byte_type rsp_q;
   logic rsp_valid_q, req_ready_q;
   logic [7:0] func_q, err_q, wr_hi_q;
   logic [15:0] addr_q, qty_q;
   logic [4:0] widx_q;
   logic [5:0] pos_q;
   logic [15:0] opcmd_q, speed_q, loop_q, ao1_q, ao2_q, contact_q, select_q;
   logic data_err_q, frst_q, fault_relay_q, pid_valid_q;
   logic [15:0] pid_q;

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   wire logic take = clk_en && req_valid && req_ready_q;
   wire drive_regs_pkg::parse_state_type eff_st =
      req.first ? drive_regs_pkg::ST_FUNC : st_q;
   wire logic is_read = (func_q == `FN_READ);
   wire logic func_bad = (req.data != `FN_READ) && (req.data != `FN_WRITE);
   wire logic [15:0] qty_full = {qty_q[15:8], req.data};
   wire logic qty_bad = (qty_full == 16'h0000) ||
      (qty_full > 16'(MAX_QTY));
   wire logic [16:0] last_full = 17'(addr_q) + 17'(qty_full) - 17'h00001;
   // monitor area and the reserved word are refused for writes
   wire logic rng_bad = is_read ? (last_full > `READ_TOP) :
      ((addr_q < `OFS_OPCMD) || (last_full > `WRITE_TOP));
   wire logic [15:0] qty_x2 = 16'(qty_q << 1);
   wire logic cnt_bad = (16'(req.data) != qty_x2);
   wire logic end_here =
      (eff_st == drive_regs_pkg::ST_QTY_L && is_read) ||
      (eff_st == drive_regs_pkg::ST_DATA_L &&
       widx_q == 5'(qty_q[4:0] - 5'h01));
   wire logic [7:0] err_new =
      (eff_st == drive_regs_pkg::ST_DRAIN) ? `ERR_NONE :
      (eff_st == drive_regs_pkg::ST_FUNC && func_bad) ? `ERR_FUNC :
      (eff_st == drive_regs_pkg::ST_QTY_L && qty_bad) ? `ERR_QTY :
      (eff_st == drive_regs_pkg::ST_QTY_L && rng_bad) ? `ERR_ADDR :
      (eff_st == drive_regs_pkg::ST_COUNT && cnt_bad) ? `ERR_QTY :
      (req.last != end_here) ? `ERR_QTY : `ERR_NONE;
   wire logic err_any = (err_q != `ERR_NONE && eff_st !=
      drive_regs_pkg::ST_FUNC) || (err_new != `ERR_NONE);
   wire drive_regs_pkg::parse_state_type st_adv =
      (eff_st == drive_regs_pkg::ST_FUNC) ? drive_regs_pkg::ST_ADDR_H :
      (eff_st == drive_regs_pkg::ST_ADDR_H) ? drive_regs_pkg::ST_ADDR_L :
      (eff_st == drive_regs_pkg::ST_ADDR_L) ? drive_regs_pkg::ST_QTY_H :
      (eff_st == drive_regs_pkg::ST_QTY_H) ? drive_regs_pkg::ST_QTY_L :
      (eff_st == drive_regs_pkg::ST_QTY_L) ? drive_regs_pkg::ST_COUNT :
      (eff_st == drive_regs_pkg::ST_DATA_H) ? drive_regs_pkg::ST_DATA_L :
      drive_regs_pkg::ST_DATA_H;
   wire drive_regs_pkg::parse_state_type st_next =
      req.last ? drive_regs_pkg::ST_REPLY :
      err_any ? drive_regs_pkg::ST_DRAIN : st_adv;

   // ------------------------------------------------------------
   // register write decode
   // ------------------------------------------------------------
   wire logic wr_en = take && eff_st == drive_regs_pkg::ST_DATA_L &&
      err_q == `ERR_NONE && err_new == `ERR_NONE;
   wire logic [15:0] wr_addr = 16'(addr_q + 16'(widx_q));
   wire logic [15:0] wr_word = {wr_hi_q, req.data};
   wire logic [15:0] wr_mask =
      (wr_addr == `OFS_OPCMD) ? `MASK_OPCMD :
      (wr_addr == `OFS_CONTACT) ? `MASK_CONTACT :
      (wr_addr == `OFS_SELECT) ? `MASK_SELECT : `MASK_FULL;
   wire logic is_ao = (wr_addr == `OFS_AO1) || (wr_addr == `OFS_AO2);
   wire logic ao_bad = is_ao && (($signed(wr_word) > `AO_MAX) ||
      ($signed(wr_word) < `AO_MIN));
   wire logic bits_bad = (wr_word & ~wr_mask) != 16'h0000;
   wire logic data_err_set = wr_en && (ao_bad || bits_bad);
   wire logic [15:0] wr_val = wr_word & wr_mask;
   wire logic wr_opcmd = wr_en && wr_addr == `OFS_OPCMD;
   wire logic frst_req = wr_opcmd && wr_val[`CMD_FRST];

   // ------------------------------------------------------------
   // monitor words
   // ------------------------------------------------------------
   wire logic [15:0] fault_word = fault_in |
      16'(opcmd_q[`CMD_EXTF]) << `FLT_EXT;
   wire logic fault_any = (fault_word != 16'h0000);
   wire logic [15:0] state_word = {8'h00,
      drive_state.out_two_on, drive_state.out_one_on,
      drive_state.relay_on, data_err_q, fault_any,
      drive_state.init_done, drive_state.reverse,
      drive_state.running};

   // ------------------------------------------------------------
   // reply byte selection
   // ------------------------------------------------------------
   wire logic [4:0] rd_off = 5'((pos_q - 6'h02) >> 1);
   wire logic [15:0] rd_addr = 16'(addr_q + 16'(rd_off));
   wire logic [15:0] rd_word =
      (rd_addr == `OFS_OPCMD) ? opcmd_q :
      (rd_addr == `OFS_SPEED) ? speed_q :
      (rd_addr == `OFS_LOOP) ? loop_q :
      (rd_addr == `OFS_AO1) ? ao1_q :
      (rd_addr == `OFS_AO2) ? ao2_q :
      (rd_addr == `OFS_CONTACT) ? contact_q :
      (rd_addr == `OFS_SELECT) ? select_q :
      (rd_addr == `OFS_STATE) ? state_word :
      (rd_addr == `OFS_FAULT) ? fault_word : 16'h0000;
   wire logic [5:0] rsp_total = (err_q != `ERR_NONE) ? 6'd2 :
      is_read ? 6'(6'd2 + 6'(qty_x2)) : 6'd5;
   wire logic [7:0] rd_byte = pos_q[0] ? rd_word[7:0] : rd_word[15:8];
   wire logic [7:0] err_byte = (pos_q == 6'd0) ?
      (func_q | `FN_ERR_BIT) : err_q;
   wire logic [7:0] ok_byte =
      (pos_q == 6'd0) ? func_q :
      (is_read && pos_q == 6'd1) ? qty_x2[7:0] :
      is_read ? rd_byte :
      (pos_q == 6'd1) ? addr_q[15:8] :
      (pos_q == 6'd2) ? addr_q[7:0] :
      (pos_q == 6'd3) ? qty_q[15:8] : qty_q[7:0];
   wire logic [7:0] rsp_byte = (err_q != `ERR_NONE) ? err_byte : ok_byte;
   wire logic rsp_move = clk_en && st_q == drive_regs_pkg::ST_REPLY &&
      (!rsp_valid_q || rsp_ready);

   // ------------------------------------------------------------
   // parser and reply sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= drive_regs_pkg::ST_FUNC;
         req_ready_q <= 1'b0;
         func_q <= 8'h00;
         err_q <= `ERR_NONE;
         addr_q <= 16'h0000;
         qty_q <= 16'h0000;
         wr_hi_q <= 8'h00;
         widx_q <= 5'h00;
         pos_q <= 6'h00;
         rsp_q <= '0;
         rsp_valid_q <= 1'b0;
      end else if (clk_en) begin
         if (take) begin
            st_q <= st_next;
            req_ready_q <= !req.last;
            if (eff_st == drive_regs_pkg::ST_FUNC) begin
               func_q <= req.data;
               err_q <= err_new;
               widx_q <= 5'h00;
               pos_q <= 6'h00;
            end else if (err_q == `ERR_NONE) begin
               err_q <= err_new;
            end
            case (eff_st)
               drive_regs_pkg::ST_ADDR_H: addr_q[15:8] <= req.data;
               drive_regs_pkg::ST_ADDR_L: addr_q[7:0] <= req.data;
               drive_regs_pkg::ST_QTY_H: qty_q[15:8] <= req.data;
               drive_regs_pkg::ST_QTY_L: qty_q[7:0] <= req.data;
               drive_regs_pkg::ST_DATA_H: wr_hi_q <= req.data;
               drive_regs_pkg::ST_DATA_L: widx_q <= 5'(widx_q + 5'h01);
               default: ;
            endcase
         end else if (st_q == drive_regs_pkg::ST_FUNC) begin
            req_ready_q <= 1'b1;
         end
         if (rsp_move) begin
            if (pos_q < rsp_total) begin
               rsp_q <= '{last: pos_q == 6'(rsp_total - 6'd1),
                          data: rsp_byte};
               rsp_valid_q <= 1'b1;
               pos_q <= 6'(pos_q + 6'd1);
            end else begin
               rsp_valid_q <= 1'b0;
               st_q <= drive_regs_pkg::ST_FUNC;
               req_ready_q <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // reference area
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         opcmd_q <= `REG_RESET;
         speed_q <= `REG_RESET;
         loop_q <= `REG_RESET;
         ao1_q <= `REG_RESET;
         ao2_q <= `REG_RESET;
         contact_q <= `REG_RESET;
         select_q <= `REG_RESET;
      end else if (clk_en && wr_en) begin
         case (wr_addr)
            `OFS_OPCMD: opcmd_q <= wr_val;
            `OFS_SPEED: speed_q <= wr_val;
            `OFS_LOOP: loop_q <= wr_val;
            `OFS_AO1: if (!ao_bad) ao1_q <= wr_val;
            `OFS_AO2: if (!ao_bad) ao2_q <= wr_val;
            `OFS_CONTACT: contact_q <= wr_val;
            `OFS_SELECT: select_q <= wr_val;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // drive-facing flags
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         data_err_q <= 1'b0;
         frst_q <= 1'b0;
         fault_relay_q <= 1'b0;
         pid_q <= `REG_RESET;
         pid_valid_q <= 1'b0;
      end else if (clk_en) begin
         // an invalid write in the reset cycle keeps the flag set
         if (data_err_set) begin
            data_err_q <= 1'b1;
         end else if (frst_req) begin
            data_err_q <= 1'b0;
         end
         frst_q <= frst_req;
         fault_relay_q <= contact_q[`CON_OVR] ?
            contact_q[`CON_FAULT] : fault_any;
         pid_q <= loop_q;
         pid_valid_q <= select_q[`SEL_LOOP];
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign req_ready = req_ready_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp = rsp_q;
   assign run_cmd = opcmd_q[`CMD_RUN];
   assign reverse_cmd = opcmd_q[`CMD_REV];
   assign remote_external_fault = opcmd_q[`CMD_EXTF];
   assign fault_reset_pulse = frst_q;
   assign remote_input_cmd = opcmd_q[`CMD_IN_LO +: 5];
   assign speed_setpoint = speed_q;
   assign pid_setpoint = pid_q;
   assign pid_setpoint_valid = pid_valid_q;
   assign analog_out_one = ao1_q;
   assign analog_out_two = ao2_q;
   assign relay_output_contact = contact_q[`CON_RELAY];
   assign photocoupler_out_one = contact_q[`CON_PH1];
   assign photocoupler_out_two = contact_q[`CON_PH2];
   assign fault_relay_contact = fault_relay_q;
   assign broadcast_enable = select_q[`SEL_BC_LO +: 3];

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_no_monitor_write;
      @(posedge clk) disable iff (rst)
      wr_en |-> (wr_addr >= `OFS_OPCMD && wr_addr <= `OFS_SELECT);
   endproperty
   a_no_monitor_write: assert property (p_no_monitor_write)
      else $error("write reached a read-only register");

   property p_unused_zero;
      @(posedge clk) disable iff (rst)
      ((opcmd_q & ~`MASK_OPCMD) == 16'h0000) &&
      ((contact_q & ~`MASK_CONTACT) == 16'h0000) &&
      ((select_q & ~`MASK_SELECT) == 16'h0000);
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused register bit holds a one");

   property p_ao_range;
      @(posedge clk) disable iff (rst)
      $signed(ao1_q) <= `AO_MAX && $signed(ao1_q) >= `AO_MIN &&
      $signed(ao2_q) <= `AO_MAX && $signed(ao2_q) >= `AO_MIN;
   endproperty
   a_ao_range: assert property (p_ao_range)
      else $error("analog level outside its range");

   property p_err_reply;
      @(posedge clk) disable iff (rst)
      (rsp_valid_q && st_q == drive_regs_pkg::ST_REPLY &&
       err_q != `ERR_NONE && pos_q == 6'd1)
      |-> rsp_q.data == (func_q | `FN_ERR_BIT) && !rsp_q.last;
   endproperty
   a_err_reply: assert property (p_err_reply)
      else $error("error reply lacks marked function code");

   property p_read_count;
      @(posedge clk) disable iff (rst)
      (rsp_valid_q && is_read && err_q == `ERR_NONE && pos_q == 6'd2 &&
       st_q == drive_regs_pkg::ST_REPLY) |-> rsp_q.data == qty_x2[7:0];
   endproperty
   a_read_count: assert property (p_read_count)
      else $error("read reply byte count wrong");

   property p_data_err;
      @(posedge clk) disable iff (rst)
      (clk_en && data_err_set) |=> data_err_q ##1 (data_err_q || frst_q);
   endproperty
   a_data_err: assert property (p_data_err)
      else $error("invalid data not flagged");

   property p_frst_pulse;
      @(posedge clk) disable iff (rst)
      (clk_en && frst_q && !frst_req) |=> !frst_q;
   endproperty
   a_frst_pulse: assert property (p_frst_pulse)
      else $error("fault reset request longer than one cycle");

   property p_pid_gate;
      @(posedge clk) disable iff (rst)
      (clk_en && !select_q[`SEL_LOOP]) |=> !pid_setpoint_valid;
   endproperty
   a_pid_gate: assert property (p_pid_gate)
      else $error("loop setpoint valid while disabled");

   property p_fault_relay;
      @(posedge clk) disable iff (rst)
      (clk_en && contact_q[`CON_OVR]) |=>
      fault_relay_contact == $past(contact_q[`CON_FAULT]);
   endproperty
   a_fault_relay: assert property (p_fault_relay)
      else $error("fault relay ignores override");

   property p_ext_fault;
      @(posedge clk) disable iff (rst)
      opcmd_q[`CMD_EXTF] |-> fault_any && state_word[3];
   endproperty
   a_ext_fault: assert property (p_ext_fault)
      else $error("external fault not reported");

   c_read: cover property (@(posedge clk) disable iff (rst)
      rsp_valid_q && rsp_q.last && is_read && err_q == `ERR_NONE);
   c_write: cover property (@(posedge clk) disable iff (rst)
      wr_en && wr_addr == `OFS_OPCMD && wr_val[`CMD_RUN]);
   c_error: cover property (@(posedge clk) disable iff (rst)
      rsp_valid_q && rsp_q.last && err_q == `ERR_ADDR);
   c_bad_data: cover property (@(posedge clk) disable iff (rst)
      data_err_set && ao_bad);
endmodule

// File: rtl/drive_regs_consts.svh
/*
 * Offsets, field positions, masks, limits and protocol codes of the
 * drive register bank. Assumes inclusion by the register bank module only.
 */
// Overview of operation
// - Reference area registers accept both reads and writes from the master; the code refuses writes to the reserved word 0.
// - Monitor area is readable; writes to it are refused.
// - Command bit 0 runs the motor when 1, stops it when 0.
// - Command bit 1 selects reverse when 1, forward when 0.
// - Command bit 2 raises an externally commanded fault.
// - Command bit 3 set requests a reset of the current fault.
// - Command bits 6 to 10 are remote input commands 3 to 7.
// - Speed setpoint holds the commanded frequency in parameter-chosen units.
// - Loop setpoint is used only while selection bit 1 is set.
// - Analog levels -726..726 map linearly onto -11 V..11 V.
// - Contact bits 0 to 2 switch relay and photocoupler outputs.
// - Contact bit 7 drives the fault relay only while bit 6 is set.
// - Selection bits 12 to 14 enable broadcast data for inputs 5 to 7.
// - Status bit 0 reads 1 while the motor is driven.
// - Status bit 1 reads 1 during reverse rotation.
// - Status bit 2 reads 1 once startup initialisation is finished.
// - Status bit 3 flags any fault; bit 4 flags invalid written data.
// - Status bits 5 to 7 show relay and two programmable outputs.
// - Fault bits 0 to 5: overcurrent, overvoltage, overload, heat, fuse.
// - Fault bits 6 to 13: feedback, external, hardware, motor, phase etc.
// - Fault bit 14 flags link error; bit 15 flags panel disconnected.
// - Function 03H reads consecutive registers, high byte first.
// - Function 10H writes consecutive registers from the start address.
// - A failed request answers function code with MSB set, then error code.
`ifndef DRIVE_REGS_CONSTS_SVH
`define DRIVE_REGS_CONSTS_SVH
`define OFS_RESERVED 16'h0000
`define OFS_OPCMD 16'h0001
`define OFS_SPEED 16'h0002
`define OFS_LOOP 16'h0006
`define OFS_AO1 16'h0007
`define OFS_AO2 16'h0008
`define OFS_CONTACT 16'h0009
`define OFS_SELECT 16'h000F
`define OFS_STATE 16'h0020
`define OFS_FAULT 16'h0021
`define WRITE_TOP 17'h0000F
`define READ_TOP 17'h00021
`define CMD_RUN 0
`define CMD_REV 1
`define CMD_EXTF 2
`define CMD_FRST 3
`define CMD_IN_LO 6
`define CON_RELAY 0
`define CON_PH1 1
`define CON_PH2 2
`define CON_OVR 6
`define CON_FAULT 7
`define SEL_LOOP 1
`define SEL_BC_LO 12
`define FLT_EXT 7
`define MASK_OPCMD 16'h07FF
`define MASK_CONTACT 16'h00C7
`define MASK_SELECT 16'h7002
`define MASK_FULL 16'hFFFF
`define AO_MAX 16'sh02D6
`define AO_MIN -16'sh02D6
`define FN_READ 8'h03
`define FN_WRITE 8'h10
`define FN_ERR_BIT 8'h80
`define ERR_NONE 8'h00
`define ERR_FUNC 8'h01
`define ERR_ADDR 8'h02
`define ERR_QTY 8'h03
`define REG_RESET 16'h0000
`endif

// File: rtl/drive_regs_pkg.sv
/*
 * Types of the drive register bank: parser states and byte carriers.
 * Assumes no other package.
 */
package drive_regs_pkg;
   // ------------------------------------------------------------
   // parser states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_FUNC, ST_ADDR_H, ST_ADDR_L, ST_QTY_H, ST_QTY_L,
      ST_COUNT, ST_DATA_H, ST_DATA_L, ST_DRAIN, ST_REPLY
   } parse_state_type;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic first;
      logic last;
      logic [7:0] data;
   } req_byte_type;
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } rsp_byte_type;
   typedef struct packed {
      logic out_two_on;
      logic out_one_on;
      logic relay_on;
      logic init_done;
      logic reverse;
      logic running;
   } drive_state_type;
endpackage

// File: test/link_master_model.sv
/*
 * master controller model: sends request bytes, gathers reply bytes.
 * assumes the bank's byte handshake, driven at the falling edge.
 */
`timescale 1ns/100ps
module link_master_model (
   input wire logic clk,
   input wire logic clk_en,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire drive_regs_pkg::rsp_byte_type rsp,
   output logic req_valid,
   output drive_regs_pkg::req_byte_type req,
   output logic rsp_ready
);
   // slow reader: takes reply bytes every other cycle when set
   logic stall;
   initial begin
      req_valid = 1'b0;
      req = '0;
      rsp_ready = 1'b0;
      stall = 1'b0;
   end
   task automatic transact(input logic [7:0] q[$],
                           output logic [7:0] r[$]);
      int n;
      r = {};
      foreach (q[i]) begin
         @(negedge clk);
         req_valid = 1'b1;
         req = {i == 0, i == q.size() - 1, q[i]};
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (!(req_ready && clk_en) && n < 64);
      end
      @(negedge clk);
      req_valid = 1'b0;
      // released data no longer shows the last byte
      req.data = ~req.data;
      for (n = 0; n < 256; n++) begin
         rsp_ready = !stall || n[0];
         @(posedge clk);
         if (rsp_valid && rsp_ready && clk_en) begin
            r.push_back(rsp.data);
            if (rsp.last) break;
         end
         @(negedge clk);
      end
      @(negedge clk);
      rsp_ready = 1'b0;
   endtask
endmodule

// File: test/testbench.sv
/*
 * self-checking bench of the register bank with a master model.
 * assumes the bank and the model are compiled before it.
 */
`timescale 1ns/100ps
`define CHK(a,b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
$display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
   logic clk, rst, clk_en, req_valid, req_ready, rsp_valid, rsp_ready;
   drive_regs_pkg::req_byte_type req;
   drive_regs_pkg::rsp_byte_type rsp;
   drive_regs_pkg::drive_state_type ds;
   logic [15:0] fault_in, speed, pid, ao1, ao2;
   logic run, rev, extf, frst, pidv, relay, ph1, ph2, fr, bad, jam;
   logic [4:0] rin;
   logic [2:0] bce;
   logic [15:0] mem [0:15];
   integer seed = 32'hED8F297B;
   int miscompares, n_tests, pulses, exp_pulses;
   drive_serial_register_map drive_serial_register_map_i (.clk(clk),
      .rst(rst), .clk_en(clk_en), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
      .rsp_ready(rsp_ready), .drive_state(ds), .fault_in(fault_in),
      .run_cmd(run), .reverse_cmd(rev), .remote_external_fault(extf),
      .fault_reset_pulse(frst), .remote_input_cmd(rin),
      .speed_setpoint(speed), .pid_setpoint(pid),
      .pid_setpoint_valid(pidv), .analog_out_one(ao1),
      .analog_out_two(ao2), .relay_output_contact(relay),
      .photocoupler_out_one(ph1), .photocoupler_out_two(ph2),
      .fault_relay_contact(fr), .broadcast_enable(bce));
   link_master_model link_master_model_i (.clk(clk), .clk_en(clk_en),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
      .req_valid(req_valid), .req(req), .rsp_ready(rsp_ready));
   // ------------------------------------------------------------
   // expectations
   // ------------------------------------------------------------
   always @(posedge clk) if (frst === 1'b1 && clk_en) pulses++;
   // random stalls of the clock enable once the random phase starts
   always @(negedge clk) if (jam) clk_en = |3'($random(seed));
   function automatic logic [15:0] msk(int a);
      case (a)
         1: return 16'h07FF;
         2, 6, 7, 8: return 16'hFFFF;
         9: return 16'h00C7;
         15: return 16'h7002;
         default: return 16'h0000;
      endcase
   endfunction
   function automatic logic [15:0] exp_word(int a);
      logic [15:0] f;
      f = fault_in | {8'h00, mem[1][2], 7'h00};
      if (a < 16) return mem[a];
      if (a == 32) return {8'h00, ds.out_two_on, ds.out_one_on,
         ds.relay_on, bad, |f, ds.init_done, ds.reverse, ds.running};
      if (a == 33) return f;
      return 16'h0000;
   endfunction
   function automatic logic [15:0] ao();
      return 16'($random(seed) % 727);
   endfunction
   // ------------------------------------------------------------
   // transfers
   // ------------------------------------------------------------
   task automatic wr(int a, logic [15:0] w[$]);
      logic [7:0] q[$], r[$];
      logic v;
      q = {8'h10, 8'h00, 8'(a), 8'h00, 8'(w.size()), 8'(2 * w.size())};
      foreach (w[i]) q = {q, w[i][15:8], w[i][7:0]};
      link_master_model_i.transact(q, r);
      for (int k = 0; k < 5; k++) `CHK(r[k], q[k])
      foreach (w[i]) begin
         v = ((a + i == 7 || a + i == 8) && ($signed(w[i]) > 726 ||
            $signed(w[i]) < -726)) || (w[i] & ~msk(a + i)) != 16'h0000;
         if (a + i == 1 && w[i][3]) begin
            bad = 1'b0;
            exp_pulses++;
         end
         if (v) bad = 1'b1;
         if (!(v && (a + i == 7 || a + i == 8)))
            mem[a + i] = w[i] & msk(a + i);
      end
   endtask
   task automatic rd(int a, int n);
      logic [7:0] r[$];
      logic [15:0] d;
      link_master_model_i.transact({8'h03, 8'h00, 8'(a), 8'h00, 8'(n)}, r);
      `CHK(r[0], 8'h03)
      `CHK(r[1], 8'(2 * n))
      for (int i = 0; i < n; i++) begin
         d = {r[2 + 2 * i], r[3 + 2 * i]};
         if (a + i < 32) `CHK(d, exp_word(a + i))
         else if (a + i == 32) `CHK(d, exp_word(32))
         else `CHK(d, exp_word(a + i))
      end
   endtask
   task automatic err(logic [7:0] q[$], logic [7:0] code);
      logic [7:0] r[$];
      link_master_model_i.transact(q, r);
      `CHK({r[0], r[1]}, {q[0] | 8'h80, code})
   endtask
   task automatic outs();
      `CHK({extf, rev, run}, mem[1][2:0])
      `CHK(rin, mem[1][10:6])
      `CHK(speed, mem[2])
      `CHK({pidv, pid}, {mem[15][1], mem[6]})
      `CHK({ao2, ao1}, {mem[8], mem[7]})
      `CHK({ph2, ph1, relay}, mem[9][2:0])
      `CHK(fr, mem[9][6] ? mem[9][7] : |exp_word(33))
      `CHK(bce, mem[15][14:12])
      `CHK(pulses, exp_pulses)
   endtask
   task complete_run();
      if (miscompares == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #100000;
      miscompares++;
      complete_run();
   end
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      ds = '0;
      fault_in = 16'h0000;
      bad = 1'b0;
      jam = 1'b0;
      foreach (mem[i]) mem[i] = 16'h0000;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      outs();
      // unused bit set, then analog values just out of range
      wr(1, {16'h8001});
      rd(1, 1);
      rd(32, 2);
      wr(7, {16'h02D7, 16'hFD29});
      rd(32, 2);
      wr(1, {16'h0008});
      outs();
      err({8'h10, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01}, 8'h02);
      err({8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00}, 8'h02);
      err({8'h05}, 8'h01);
      err({8'h03, 8'h00, 8'h21, 8'h00, 8'h02}, 8'h02);
      err({8'h03, 8'h00, 8'h00, 8'h00, 8'h11}, 8'h03);
      // byte count not twice the quantity, then a frame cut short
      err({8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h04, 8'h00, 8'h00}, 8'h03);
      err({8'h03, 8'h00, 8'h20, 8'h00}, 8'h03);
      // second reset in mid-run brings every output back to zero
      wr(9, {16'h00C7});
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      foreach (mem[i]) mem[i] = 16'h0000;
      bad = 1'b0;
      outs();
      jam = 1'b1;
      repeat (12) begin
         @(negedge clk);
         ds = 6'($random(seed));
         fault_in = 16'($random(seed));
         link_master_model_i.stall = 1'($random(seed));
         wr(1, {16'($random(seed)) & 16'h07F7, 16'($random(seed))});
         wr(6, {16'($random(seed)), ao(), ao(), 16'($random(seed)) &
            16'h00C7, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
            16'($random(seed)) & 16'h7002});
         rd(0, 16);
         rd(32, 2);
         outs();
      end
      complete_run();
   end
endmodule
